// ===== chsh_config.sv
// Channel-pair enables, link scaling and sync-header selection behind a Wishbone slave
//
// Our own choice: the Wishbone slave port.
module chsh_config
  import chsh_pkg::*;
#(
  parameter int FULL_LANES = 8,
  parameter int FULL_CONVS = 4
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [CHSH_AW-1:0] adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  output logic                   err_o,
  // Channel enables, A to D
  output logic      [3:0]        chan_enable_o,
  // Link shape
  output logic      [3:0]        lane_count_o,
  output logic      [3:0]        conv_count_o,
  output logic                   tail_bits_o,
  output logic                   remap_upper_o,
  // Link and calibration controls
  output logic                   link_enable_o,
  output logic                   cal_enable_o,
  // Sync-header stream
  output logic                   hdr_crc12_o,
  output logic                   hdr_fec_o,
  output logic      [7:0]        hdr_command_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] chan_reg;
  logic [7:0] sync_reg;
  logic [7:0] link_reg;
  logic       ack_reg;
  logic       err_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic       req;
  logic       hit;
  logic       wr_ack;

  function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [31:0] d, input logic s);
    merge_byte = s ? d[7:0] : old_v;
  endfunction : merge_byte

  assign req = cyc_i && stb_i && !ack_reg && !err_reg;
  assign wr_ack = cyc_i && stb_i && we_i && ack_reg;
  assign hit = (adr_i == CHSH_ADDR_CHAN) || (adr_i == CHSH_ADDR_SYNC) ||
               (adr_i == CHSH_ADDR_LINK) || (adr_i == CHSH_ADDR_DERIVED);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      ack_reg <= req && hit;
      err_reg <= req && !hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_reg <= CHSH_RST_CHAN;
      sync_reg <= CHSH_RST_SYNC;
      link_reg <= CHSH_RST_LINK;
    end else if (wr_ack) begin
      if (adr_i == CHSH_ADDR_CHAN) begin
        chan_reg <= merge_byte(chan_reg, dat_i, sel_i[0]);
      end
      if (adr_i == CHSH_ADDR_SYNC) begin
        sync_reg <= merge_byte(sync_reg, dat_i, sel_i[0]);
      end
      if (adr_i == CHSH_ADDR_LINK) begin
        link_reg <= merge_byte(link_reg, dat_i, sel_i[0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Derived link configuration
  logic single_ch;
  logic lower_en;
  logic upper_en;
  logic pair_off;
  logic [3:0] lanes_next;
  logic [3:0] convs_next;
  chsh_hdr_t  hdr_next;

  assign single_ch = chan_reg[CHSH_BIT_SINGLE];
  assign lower_en  = chan_reg[CHSH_BIT_LOWER];
  assign upper_en  = chan_reg[CHSH_BIT_UPPER] && !single_ch;
  assign pair_off  = !lower_en || !upper_en;

  always_comb begin
    lanes_next = 4'(FULL_LANES);
    convs_next = 4'(FULL_CONVS);
    if (pair_off) begin
      lanes_next = 4'((FULL_LANES + 1) / 2);
      convs_next = 4'(FULL_CONVS / 2);
    end
  end

  always_comb begin
    hdr_next = CHSH_HDR_NONE;
    if (link_reg[CHSH_BIT_66B]) begin
      unique case (sync_reg[1:0])
        CHSH_SH_CRC12: hdr_next = CHSH_HDR_CRC12;
        CHSH_SH_FEC:   hdr_next = CHSH_HDR_FEC;
        default:       hdr_next = CHSH_HDR_NONE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_enable_o <= 4'hF;
      lane_count_o  <= 4'(FULL_LANES);
      conv_count_o  <= 4'(FULL_CONVS);
      tail_bits_o   <= 1'b0;
      remap_upper_o <= 1'b0;
    end else begin
      chan_enable_o[0] <= lower_en;
      chan_enable_o[1] <= lower_en && !single_ch;
      chan_enable_o[2] <= upper_en;
      chan_enable_o[3] <= upper_en;
      lane_count_o     <= lanes_next;
      conv_count_o     <= convs_next;
      tail_bits_o      <= pair_off && (FULL_LANES % 2 == 1);
      remap_upper_o    <= !lower_en && upper_en;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hdr_crc12_o   <= 1'b0;
      hdr_fec_o     <= 1'b0;
      hdr_command_o <= 8'h00;
    end else begin
      hdr_crc12_o   <= hdr_next == CHSH_HDR_CRC12;
      hdr_fec_o     <= hdr_next == CHSH_HDR_FEC;
      hdr_command_o <= 8'h00;
    end
  end

  assign link_enable_o = link_reg[CHSH_BIT_LINKEN];
  assign cal_enable_o  = link_reg[CHSH_BIT_CALEN];

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (adr_i)
      CHSH_ADDR_CHAN:    rdata_next = {24'h000000, chan_reg};
      CHSH_ADDR_SYNC:    rdata_next = {24'h000000, sync_reg};
      CHSH_ADDR_LINK:    rdata_next = {24'h000000, link_reg};
      CHSH_ADDR_DERIVED: rdata_next = {16'h0000, remap_upper_o, tail_bits_o, 2'b00,
                                       chan_enable_o, conv_count_o, lane_count_o};
      default:           rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (req && !we_i) begin
      rdata_reg <= rdata_next;
    end
  end

  assign dat_o = rdata_reg;
  assign ack_o = ack_reg;
  assign err_o = err_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_single_kills_bcd: assert property (@(posedge clk_i) disable iff (rst_i)
    single_ch |=> chan_enable_o[3:1] == 3'b000 || $past(rst_i))
    else $error("single-channel mode left B, C or D enabled");
  a_upper_pair_en: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> chan_enable_o[2] == $past(upper_en))
    else $error("upper pair enable mismatch");
  a_lower_pair_en: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> chan_enable_o[0] == $past(lower_en))
    else $error("lower pair enable mismatch");
  a_lane_halving: assert property (@(posedge clk_i) disable iff (rst_i)
    pair_off |=> lane_count_o == 4'((FULL_LANES + 1) / 2) && conv_count_o == 4'(FULL_CONVS / 2))
    else $error("lane or converter count not halved");
  a_tail_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    tail_bits_o |-> $past(pair_off) && FULL_LANES % 2 == 1)
    else $error("tail bits without odd halved lanes");
  a_remap_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(remap_upper_o) |-> $past(!lower_en))
    else $error("remap without lower pair disabled");
  a_hdr_only_66b: assert property (@(posedge clk_i) disable iff (rst_i)
    !link_reg[CHSH_BIT_66B] ##1 !link_reg[CHSH_BIT_66B] |-> !hdr_crc12_o && !hdr_fec_o)
    else $error("sync header selection outside 64B/66B");
  a_hdr_fec_code: assert property (@(posedge clk_i) disable iff (rst_i)
    hdr_fec_o |-> $past(sync_reg[1:0]) == CHSH_SH_FEC)
    else $error("FEC header without select value 2");
  a_cmd_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    hdr_command_o == 8'h00)
    else $error("command field not idle");
  a_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ack && adr_i == CHSH_ADDR_SYNC && sel_i[0] |=> sync_reg == $past(dat_i[7:0]))
    else $error("sync select did not store written value");

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake and storage checks

  a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o
    |=> !ack_o)
    else $error("acknowledge longer than one cycle");

  a_err_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    err_o
    |=> !err_o)
    else $error("error longer than one cycle");

  a_ack_err_apart: assert property (@(posedge clk_i) disable iff (rst_i)
    !(ack_o &&
      err_o))
    else $error("acknowledge and error together");

  a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o
    |-> $past(cyc_i && stb_i && hit))
    else $error("acknowledge without mapped request");

  a_err_after_miss: assert property (@(posedge clk_i) disable iff (rst_i)
    err_o
    |-> $past(cyc_i && stb_i && !hit))
    else $error("error without unmapped request");

  a_write_on_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_ack
    |=> $stable(chan_reg) && $stable(sync_reg) && $stable(link_reg))
    else $error("register changed outside a write");

  a_chan_store: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ack && adr_i == CHSH_ADDR_CHAN && sel_i[0]
    |=> chan_reg == $past(dat_i[7:0]))
    else $error("channel register did not store written value");

  a_link_store: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ack && adr_i == CHSH_ADDR_LINK && sel_i[0]
    |=> link_reg == $past(dat_i[7:0]))
    else $error("link control did not store written value");

  a_sel_masked: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ack && !sel_i[0]
    |=> $stable(chan_reg) && $stable(sync_reg) && $stable(link_reg))
    else $error("masked byte was written");

  a_read_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && !we_i
    |=> $stable(chan_reg) && $stable(sync_reg) && $stable(link_reg))
    else $error("read changed a register");

  a_read_sync_data: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && $past(!we_i && adr_i == CHSH_ADDR_SYNC)
    |-> dat_o == {24'h000000, $past(sync_reg)})
    else $error("sync select read data wrong");

  a_read_chan_data: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && $past(!we_i && adr_i == CHSH_ADDR_CHAN)
    |-> dat_o == {24'h000000, $past(chan_reg)})
    else $error("channel register read data wrong");

  a_miss_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    err_o && $past(!we_i)
    |-> dat_o == 32'h0000_0000)
    else $error("unmapped read data not zero");

  a_rdata_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(req && !we_i)
    |-> $stable(dat_o))
    else $error("read data changed without a read");

  ////////////////////////////////////////////////////////////////////////////
  // Channel, shape and header checks

  a_lower_b_chan: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i)
    |-> chan_enable_o[1] == $past(lower_en && !single_ch))
    else $error("channel B enable mismatch");

  a_upper_d_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i)
    |-> chan_enable_o[3] == chan_enable_o[2])
    else $error("channels C and D split");

  a_single_a_only: assert property (@(posedge clk_i) disable iff (rst_i)
    single_ch
    |=> chan_enable_o[0] == $past(lower_en))
    else $error("channel A wrong in single-channel mode");

  a_full_shape: assert property (@(posedge clk_i) disable iff (rst_i)
    !pair_off
    |=> lane_count_o == 4'(FULL_LANES) && conv_count_o == 4'(FULL_CONVS))
    else $error("full lane or converter count wrong");

  a_single_halves: assert property (@(posedge clk_i) disable iff (rst_i)
    single_ch
    |=> lane_count_o == 4'((FULL_LANES + 1) / 2))
    else $error("single-channel lane count not halved");

  a_tail_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    pair_off
    |=> tail_bits_o == (FULL_LANES % 2 == 1))
    else $error("tail bits wrong for halved link");

  a_remap_slots: assert property (@(posedge clk_i) disable iff (rst_i)
    remap_upper_o
    |-> chan_enable_o == 4'hC)
    else $error("remap with wrong channels enabled");

  a_hdr_exclusive: assert property (@(posedge clk_i) disable iff (rst_i)
    !(hdr_crc12_o &&
      hdr_fec_o))
    else $error("two header kinds at once");

  a_hdr_crc_code: assert property (@(posedge clk_i) disable iff (rst_i)
    hdr_crc12_o
    |-> $past(sync_reg[1:0]) == CHSH_SH_CRC12 && $past(link_reg[CHSH_BIT_66B]))
    else $error("CRC-12 header without select value 0");

  a_hdr_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
    link_reg[CHSH_BIT_66B] && sync_reg[0]
    |=> !hdr_crc12_o && !hdr_fec_o)
    else $error("header sent for reserved select");

endmodule : chsh_config

// ===== chsh_config_tb_top.sv
// Testbench for the channel and sync-header configuration block
module chsh_config_tb_top;
  import chsh_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, e, bad_hdr;
  logic        tail_bits_o, remap_upper_o, link_enable_o, cal_enable_o, hdr_crc12_o, hdr_fec_o;
  logic [13:0] adr_i;
  logic [3:0]  sel_i, chan_enable_o, lane_count_o, conv_count_o;
  logic [31:0] dat_i, dat_o;
  logic [7:0]  hdr_command_o, q;
  logic [2:0]  cv [4] = '{3'h3, 3'h2, 3'h1, 3'h5};
  int          fail_count = 0;
  int          cmp_count = 0;

  chsh_config #(.FULL_LANES(7), .FULL_CONVS(4)) DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .err_o, .chan_enable_o, .lane_count_o, .conv_count_o, .tail_bits_o,
    .remap_upper_o, .link_enable_o, .cal_enable_o, .hdr_crc12_o, .hdr_fec_o, .hdr_command_o);
  chsh_rx_model RX (.clk_i, .rst_i, .link_enable_i(link_enable_o), .hdr_crc12_i(hdr_crc12_o),
    .hdr_fec_i(hdr_fec_o), .hdr_command_i(hdr_command_o), .bad_hdr_o(bad_hdr));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task chk(input string nm, input logic [7:0] s, input logic [7:0] x);
    cmp_count++;
    if (s !== x) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  // One classic Wishbone cycle; read data and error land in q and e
  task automatic wb(input logic w, input logic [13:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1 && err_o !== 1'b1) begin
      fail_count++;
      $display("MISMATCH ack expected 1 seen 0");
      give_verdict();
    end else begin
      q = dat_o[7:0];
      e = err_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask : wb

  initial begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
    sel_i = 4'hF;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("reset_chan", {4'h0, chan_enable_o}, 8'h0F);
    chk("reset_shape", {lane_count_o, conv_count_o}, 8'h74);
    wb(1'b0, CHSH_ADDR_CHAN, 8'h00);
    chk("chan_reg", q, 8'h03);
    wb(1'b0, CHSH_ADDR_SYNC, 8'h00);
    chk("sync_reg", q, 8'h00);
    $display("test reset done");
    foreach (cv[i]) begin
      logic off;
      off = cv[i][2] | ~(cv[i][0] & cv[i][1]);
      wb(1'b1, CHSH_ADDR_LINK, 8'h00);
      wb(1'b1, CHSH_ADDR_CHAN, {5'h0, cv[i]});
      repeat (2) @(posedge clk_i);
      chk("chan_en", {4'h0, chan_enable_o}, cv[i][2] ? {7'h0, cv[i][0]} : {4'h0, {2{cv[i][1]}}, {2{cv[i][0]}}});
      chk("shape", {lane_count_o, conv_count_o}, off ? 8'h42 : 8'h74);
      chk("tail_remap", {6'h0, tail_bits_o, remap_upper_o}, {6'h0, off, ~cv[i][2] & ~cv[i][0] & cv[i][1]});
      wb(1'b0, CHSH_ADDR_CHAN, 8'h00);
      chk("chan_back", q, {5'h0, cv[i]});
    end
    $display("test channels done");
    wb(1'b1, CHSH_ADDR_LINK, 8'h04);
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, CHSH_ADDR_SYNC, 8'(s));
      repeat (2) @(posedge clk_i);
      chk("hdr_sel", {6'h0, hdr_crc12_o, hdr_fec_o}, {6'h0, s == 0, s == 2});
      chk("hdr_cmd", hdr_command_o, 8'h00);
      wb(1'b0, CHSH_ADDR_SYNC, 8'h00);
      chk("sync_back", q, 8'(s));
    end
    wb(1'b1, CHSH_ADDR_LINK, 8'h00);
    wb(1'b1, CHSH_ADDR_SYNC, 8'h02);
    repeat (2) @(posedge clk_i);
    chk("hdr_8b10b", {6'h0, hdr_crc12_o, hdr_fec_o}, 8'h00);
    wb(1'b1, CHSH_ADDR_LINK, 8'h07);
    repeat (2) @(posedge clk_i);
    chk("link_up", {4'h0, link_enable_o, cal_enable_o, hdr_crc12_o, hdr_fec_o}, 8'h0D);
    chk("rx_hdr", {7'h0, bad_hdr}, 8'h00);
    $display("test sync header done");
    wb(1'b1, 14'h0000, 8'hFF);
    chk("unmapped_err", {7'h0, e}, 8'h01);
    sel_i <= 4'hE;
    wb(1'b1, CHSH_ADDR_CHAN, 8'h00);
    sel_i <= 4'hF;
    wb(1'b0, CHSH_ADDR_CHAN, 8'h00);
    chk("chan_kept", q, 8'h05);
    wb(1'b0, CHSH_ADDR_DERIVED, 8'h00);
    chk("derived", q, 8'h24);
    $display("test unmapped done");
    give_verdict();
  end
endmodule : chsh_config_tb_top

// ===== chsh_pkg.sv
// Package: register map, field layout and encodings for the channel and sync-header configuration block
package chsh_pkg;

  // Register byte addresses (printed offsets are not all multiples of four, so index * 4)
  localparam logic [11:0] CHSH_IDX_CHAN     = 12'h209;
  localparam logic [11:0] CHSH_IDX_SYNC     = 12'h20F;
  localparam logic [11:0] CHSH_IDX_LINK     = 12'h300;
  localparam logic [11:0] CHSH_IDX_DERIVED  = 12'h301;
  localparam int          CHSH_AW           = 14;
  localparam logic [13:0] CHSH_ADDR_CHAN    = {CHSH_IDX_CHAN, 2'b00};
  localparam logic [13:0] CHSH_ADDR_SYNC    = {CHSH_IDX_SYNC, 2'b00};
  localparam logic [13:0] CHSH_ADDR_LINK    = {CHSH_IDX_LINK, 2'b00};
  localparam logic [13:0] CHSH_ADDR_DERIVED = {CHSH_IDX_DERIVED, 2'b00};

  // Field positions
  localparam int CHSH_BIT_LOWER  = 0;
  localparam int CHSH_BIT_UPPER  = 1;
  localparam int CHSH_BIT_SINGLE = 2;
  localparam int CHSH_BIT_LINKEN = 0;
  localparam int CHSH_BIT_CALEN  = 1;
  localparam int CHSH_BIT_66B    = 2;

  // Reset values
  localparam logic [7:0] CHSH_RST_CHAN = 8'h03;
  localparam logic [7:0] CHSH_RST_SYNC = 8'h00;
  localparam logic [7:0] CHSH_RST_LINK = 8'h00;

  // Sync-header select encodings
  localparam logic [1:0] CHSH_SH_CRC12 = 2'h0;
  localparam logic [1:0] CHSH_SH_FEC   = 2'h2;

  typedef enum logic [2:0] {
    CHSH_HDR_NONE  = 3'b001,
    CHSH_HDR_CRC12 = 3'b010,
    CHSH_HDR_FEC   = 3'b100
  } chsh_hdr_t;

endpackage : chsh_pkg

// ===== chsh_rx_model.sv
// Far-side link receiver model that watches the sync-header stream
module chsh_rx_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Header stream from the block
  input  wire logic       link_enable_i,
  input  wire logic       hdr_crc12_i,
  input  wire logic       hdr_fec_i,
  input  wire logic [7:0] hdr_command_i,
  // Sticky flag for an illegal header
  output logic            bad_hdr_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // While the link is enabled, the receiver accepts only idle commands and one header kind
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bad_hdr_o <= 1'b0;
    end else if (link_enable_i && (hdr_command_i != 8'h00 || (hdr_crc12_i && hdr_fec_i))) begin
      bad_hdr_o <= 1'b1;
    end
  end
endmodule : chsh_rx_model
